// file: hw/nvm_pkg.sv
// shared constants and types of the data eeprom access and write guard block
// assumes one 20 MHz clock and a word-aligned avalon-mm register map
package nvm_pkg;

  // ****************************************
  // array geometry
  // ****************************************
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int DEPTH  = 64;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [4:0] OFS_ADDR = 5'h00;  // nvm_address_reg
  localparam logic [4:0] OFS_DATA = 5'h04;  // nvm_data_reg
  localparam logic [4:0] OFS_BANK = 5'h08;  // bank_select_pointer
  localparam logic [4:0] OFS_PTR  = 5'h0c;  // indirect_pointer_one
  localparam logic [4:0] OFS_PORT = 5'h10;  // indirect_access_port_one
  localparam logic [4:0] OFS_IRQ  = 5'h14;  // interrupt enables and flags
  localparam logic [4:0] OFS_STAT = 5'h18;  // busy and fail status

  // the control register is reached only at this pointer in this bank
  localparam logic [7:0] CTRL_PTR  = 8'h40;
  localparam logic [7:0] CTRL_BANK = 8'h01;

  // ****************************************
  // field positions
  // ****************************************
  localparam int RD_TRIG_BIT   = 0;
  localparam int RD_PERMIT_BIT = 1;
  localparam int WR_TRIG_BIT   = 2;
  localparam int WR_PERMIT_BIT = 3;
  localparam int GIE_BIT       = 0;
  localparam int MF_IE_BIT     = 1;
  localparam int NVM_IE_BIT    = 2;
  localparam int MF_FLAG_BIT   = 3;
  localparam int NVM_FLAG_BIT  = 4;
  localparam int BUSY_BIT      = 0;
  localparam int FAIL_BIT      = 1;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_TIME_NS  = 1000;
  localparam int TICK_DIV      = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int WRITE_TIME_US = 2000;
  localparam int WRITE_TICKS   = WRITE_TIME_US * 1000 / TICK_TIME_NS;
  localparam int DIV_W         = 8;
  localparam int TICK_W        = 16;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_LOAD, ST_WRITE} nvm_state_t;

  typedef struct packed {
    logic              we;
    logic              re;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [7:0]        bank;
    logic [7:0]        ptr;
    logic              write_permit;
    logic              wr_trig;
    logic              read_permit;
    logic              rd_trig;
    logic              global_irq_enable;
    logic              mf_irq_enable;
    logic              nvm_irq_enable;
    logic              mf_irq_flag;
    logic              nvm_irq_flag;
    logic              fail;
    nvm_state_t        st;
    logic [DIV_W-1:0]  div;
    logic [TICK_W-1:0] ticks;
    logic              ack;
    logic [31:0]       rdata;
  } guard_state_t;

endpackage

// file: hw/nvm_cell_array.sv
// 64 x 8 nonvolatile cell array with registered read data
// assumes at most one of read or write per cycle, driven by the guard logic
`timescale 1ns/100ps
`default_nettype none

module nvm_cell_array (
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  // access request
  input  wire nvm_pkg::mem_req_t req_i,
  // read data
  output logic [7:0]             rdata_o
);

  typedef struct packed {
    logic [nvm_pkg::DEPTH-1:0][nvm_pkg::DATA_W-1:0] cells;
    logic [nvm_pkg::DATA_W-1:0]                     rdata;
  } cell_state_t;

  cell_state_t s_reg;
  cell_state_t s_next;

  // cells keep their content over reset, only the read register clears
  always_comb begin
    s_next = s_reg;
    if (req_i.we) begin
      s_next.cells[req_i.addr] = req_i.wdata;
    end
    if (req_i.re) begin
      s_next.rdata = s_reg.cells[req_i.addr];
    end
    if (reset_i) begin
      s_next.rdata = 8'h00;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    s_reg <= s_next;
  end

  assign rdata_o = s_reg.rdata;

endmodule

`default_nettype wire

// file: hw/eeprom_access_write_guard.sv
// data eeprom access control: banked control register, timed write, interrupt flags
// assumes an avalon-mm master with waitrequest and a cpu core giving halt and stack state
`timescale 1ns/100ps
`default_nettype none

module eeprom_access_write_guard #(
  parameter int                          TICK_DIV    = nvm_pkg::TICK_DIV,
  parameter logic [nvm_pkg::TICK_W-1:0]  WRITE_TICKS = nvm_pkg::TICK_W'(nvm_pkg::WRITE_TICKS)
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // cpu core side
  input  wire logic        power_down_i,
  input  wire logic        stack_full_i,
  input  wire logic        irq_ack_i,
  output logic             irq_vector_req_o,
  output logic             nvm_busy_o
);

  localparam logic [nvm_pkg::DIV_W-1:0] DIV_LAST = nvm_pkg::DIV_W'(TICK_DIV - 1);

  nvm_pkg::guard_state_t s_reg;
  nvm_pkg::guard_state_t s_next;
  nvm_pkg::mem_req_t     mem_req;
  logic [7:0]            mem_rdata;

  // ****************************************
  // cell array
  // ****************************************
  nvm_cell_array u_cells (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .req_i     (mem_req),
    .rdata_o   (mem_rdata)
  );

  // ****************************************
  // next state
  // ****************************************
  logic       tick;
  logic       ctrl_sel;
  logic       wr_last;
  logic       bus_req;
  logic       wr_take;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  // one comb process: bus, sequencer, flags; hardware sets come last so they win
  always_comb begin
    s_next   = s_reg;
    tick     = (s_reg.div == DIV_LAST);
    ctrl_sel = (s_reg.bank == nvm_pkg::CTRL_BANK) && (s_reg.ptr == nvm_pkg::CTRL_PTR);
    wr_last  = tick && (s_reg.ticks == WRITE_TICKS - nvm_pkg::TICK_W'(1));
    bus_req  = avs_read || avs_write;
    wr_take  = avs_write && s_reg.ack && avs_byteenable[0];
    wbyte    = avs_writedata[7:0];
    mem_req  = '0;
    rbyte    = 8'h00;

    // tick divider stands in for the slow write timer clock
    s_next.div = tick ? '0 : s_reg.div + nvm_pkg::DIV_W'(1);

    // read mux; unmapped offsets and other bank 1 words read zero
    case (avs_address)
      nvm_pkg::OFS_ADDR: rbyte = {2'h0, s_reg.addr};
      nvm_pkg::OFS_DATA: rbyte = s_reg.data;
      nvm_pkg::OFS_BANK: rbyte = s_reg.bank;
      nvm_pkg::OFS_PTR:  rbyte = s_reg.ptr;
      nvm_pkg::OFS_PORT: rbyte = ctrl_sel ? {4'h0, s_reg.write_permit, s_reg.wr_trig,
                                             s_reg.read_permit, s_reg.rd_trig} : 8'h00;
      nvm_pkg::OFS_IRQ:  rbyte = {3'h0, s_reg.nvm_irq_flag, s_reg.mf_irq_flag,
                                  s_reg.nvm_irq_enable, s_reg.mf_irq_enable, s_reg.global_irq_enable};
      nvm_pkg::OFS_STAT: rbyte = {6'h00, s_reg.fail, s_reg.st != nvm_pkg::ST_IDLE};
      default:           rbyte = 8'h00;
    endcase

    // one wait cycle, then the answer; read data is captured in the wait cycle
    s_next.ack = bus_req && !s_reg.ack;
    if (bus_req && !s_reg.ack) begin
      s_next.rdata = {24'h000000, rbyte};
    end

    // software writes take effect at the edge where waitrequest is low
    if (wr_take) begin
      case (avs_address)
        nvm_pkg::OFS_ADDR: s_next.addr = wbyte[nvm_pkg::ADDR_W-1:0];
        nvm_pkg::OFS_DATA: s_next.data = wbyte;
        nvm_pkg::OFS_BANK: s_next.bank = wbyte;
        nvm_pkg::OFS_PTR:  s_next.ptr  = wbyte;
        nvm_pkg::OFS_PORT: begin
          if (ctrl_sel) begin
            s_next.write_permit = wbyte[nvm_pkg::WR_PERMIT_BIT];
            s_next.read_permit  = wbyte[nvm_pkg::RD_PERMIT_BIT];
            // a trigger counts only if its permit was already set; busy ignores starts
            if (s_reg.st == nvm_pkg::ST_IDLE) begin
              if (wbyte[nvm_pkg::WR_TRIG_BIT] && s_reg.write_permit) begin
                s_next.wr_trig = 1'b1;
                s_next.fail    = 1'b0;
                s_next.ticks   = '0;
                s_next.st      = nvm_pkg::ST_WRITE;
              end else if (wbyte[nvm_pkg::RD_TRIG_BIT] && s_reg.read_permit) begin
                s_next.rd_trig = 1'b1;
                s_next.fail    = 1'b0;
                s_next.st      = nvm_pkg::ST_READ;
              end
            end
          end
        end
        nvm_pkg::OFS_IRQ: begin
          s_next.global_irq_enable = wbyte[nvm_pkg::GIE_BIT];
          s_next.mf_irq_enable     = wbyte[nvm_pkg::MF_IE_BIT];
          s_next.nvm_irq_enable    = wbyte[nvm_pkg::NVM_IE_BIT];
          s_next.mf_irq_flag       = wbyte[nvm_pkg::MF_FLAG_BIT];
          s_next.nvm_irq_flag      = wbyte[nvm_pkg::NVM_FLAG_BIT];  // only software or reset clears it
        end
        default: begin
        end
      endcase
    end

    // vector taken clears the parent flag only; the nvm flag stays set
    if (irq_ack_i) begin
      s_next.mf_irq_flag = 1'b0;
    end

    // access sequencer
    case (s_reg.st)
      nvm_pkg::ST_READ: begin
        mem_req.re   = 1'b1;
        mem_req.addr = s_reg.addr;
        s_next.st    = nvm_pkg::ST_LOAD;
      end
      nvm_pkg::ST_LOAD: begin
        // a halt in the load cycle leaves the old data in place
        if (!power_down_i) begin
          s_next.data = mem_rdata;  // held until the next access
        end
        s_next.rd_trig = 1'b0;
        s_next.st      = nvm_pkg::ST_IDLE;
      end
      nvm_pkg::ST_WRITE: begin
        if (tick) begin
          s_next.ticks = s_reg.ticks + nvm_pkg::TICK_W'(1);
        end
        if (wr_last && !power_down_i) begin
          mem_req.we          = 1'b1;
          mem_req.addr        = s_reg.addr;
          mem_req.wdata       = s_reg.data;
          s_next.wr_trig      = 1'b0;
          s_next.nvm_irq_flag = 1'b1;  // only writes get here
          s_next.mf_irq_flag  = 1'b1;  // set wins over a same-cycle clear
          s_next.st           = nvm_pkg::ST_IDLE;
        end
      end
      default: begin
      end
    endcase

    // halting mid access aborts it; the sequencer already held back store, flags and load,
    // so software updates made in this same cycle still stand
    if (power_down_i && (s_reg.st != nvm_pkg::ST_IDLE)) begin
      s_next.wr_trig = 1'b0;
      s_next.rd_trig = 1'b0;
      s_next.fail    = 1'b1;
      s_next.st      = nvm_pkg::ST_IDLE;
    end

    // synchronous reset: permits off, bank zero, everything idle
    if (reset_i) begin
      s_next = '0;  // clears write_permit and bank
      mem_req = '0;  // no store lands on the reset edge
      s_next.st = nvm_pkg::ST_IDLE;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    s_reg <= s_next;
  end

  // ****************************************
  // outputs
  // ****************************************
  // vector only with all three enables and room on the stack
  assign irq_vector_req_o = s_reg.global_irq_enable && s_reg.nvm_irq_enable &&
                            s_reg.mf_irq_enable && s_reg.mf_irq_flag && !stack_full_i;
  assign avs_waitrequest  = (avs_read || avs_write) && !s_reg.ack;
  assign avs_readdata     = s_reg.rdata;
  assign nvm_busy_o       = (s_reg.st != nvm_pkg::ST_IDLE);

endmodule

`default_nettype wire

// file: sim/guard_monitor.sv
// port checker for the eeprom access and write guard
// assumes the guard's top ports only; bound at the foot
`timescale 1ns/100ps
`default_nettype none
module guard_monitor #(
  parameter int                         TICK_DIV    = 2,
  parameter logic [nvm_pkg::TICK_W-1:0] WRITE_TICKS = 16
) (
  // clock and bus
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // core side
  input wire logic        power_down_i,
  input wire logic        stack_full_i,
  input wire logic        irq_ack_i,
  input wire logic        irq_vector_req_o,
  input wire logic        nvm_busy_o
);
  // ****************************************
  // properties
  // ****************************************
  // longest write plus two ticks of divider phase slack and four cycles
  localparam int MAXW = (int'(WRITE_TICKS) + 2) * TICK_DIV + 4;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  property p_quiet; $fell(reset_i) |-> !nvm_busy_o && !irq_vector_req_o; endproperty
  a_quiet: assert property (p_quiet) else $error("busy or vector after reset");
  property p_bound; $rose(nvm_busy_o) |-> ##[1:MAXW] !nvm_busy_o; endproperty
  a_bound: assert property (p_bound) else $error("access never ends");
  property p_halt; power_down_i && nvm_busy_o |-> ##[1:2] !nvm_busy_o; endproperty
  a_halt: assert property (p_halt) else $error("halt did not abort");
  property p_stack; stack_full_i |-> !irq_vector_req_o; endproperty
  a_stack: assert property (p_stack) else $error("vector with full stack");
  property p_cause; $rose(irq_vector_req_o) |-> $fell(nvm_busy_o) || $past(avs_write) || $fell(stack_full_i); endproperty
  a_cause: assert property (p_cause) else $error("vector without cause");
  property p_ack; irq_ack_i && !nvm_busy_o |=> !irq_vector_req_o; endproperty
  a_ack: assert property (p_ack) else $error("vector kept after ack");
  property p_upper; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_wait; $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
endmodule
bind eeprom_access_write_guard guard_monitor #(.TICK_DIV(TICK_DIV), .WRITE_TICKS(WRITE_TICKS)) u_mon (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .power_down_i(power_down_i),
  .stack_full_i(stack_full_i), .irq_ack_i(irq_ack_i), .irq_vector_req_o(irq_vector_req_o),
  .nvm_busy_o(nvm_busy_o));
`default_nettype wire

// file: sim/cpu_core_model.sv
// stand-in for the cpu core: takes the vector when allowed
// assumes the guard's clock and reset
`timescale 1ns/100ps
`default_nettype none
module cpu_core_model (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  // vector handshake
  input  wire logic take_en_i,
  input  wire logic vector_req_i,
  output logic      irq_ack_o
);
  // one pulse per vector; the gap lets the request drop before a second take
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) irq_ack_o <= 1'b0;
    else irq_ack_o <= take_en_i && vector_req_i && !irq_ack_o;
  end
endmodule
`default_nettype wire

// file: sim/eeprom_access_write_guard_tb.sv
// self-checking bench for the eeprom access and write guard
// assumes a short write time set by parameters
`timescale 1ns/100ps
`default_nettype none
module eeprom_access_write_guard_tb;
  logic ref_clk_i, reset_i, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic power_down_i, stack_full_i, irq_ack_i, irq_vector_req_o, nvm_busy_o, take_en;
  logic [3:0] lane_en;
  int err_count = 0;
  int compares = 0;
  eeprom_access_write_guard #(.TICK_DIV(2), .WRITE_TICKS(16)) dut (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(lane_en), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .power_down_i(power_down_i), .stack_full_i(stack_full_i),
    .irq_ack_i(irq_ack_i), .irq_vector_req_o(irq_vector_req_o), .nvm_busy_o(nvm_busy_o));
  cpu_core_model core (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .take_en_i(take_en),
    .vector_req_i(irq_vector_req_o), .irq_ack_o(irq_ack_i));
  // ****************************************
  // tasks
  // ****************************************
  task automatic tally_and_finish;
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one avalon transfer; held until waitrequest is seen low, then one idle cycle
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !w;
    avs_write <= w;
    @(posedge ref_clk_i);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk_i);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  // poll a control bit until the hardware clears it, bounded
  task automatic poll(input int b);
    logic [7:0] q;
    q = 8'hff;
    repeat (40) if (q[b] !== 1'b0) bus(1'b0, 5'h10, 8'h00, q);
    chk(q & (8'h01 << b), 8'h00);
  endtask
  task automatic open_ctl(input logic [5:0] a);
    wr(5'h00, {2'b00, a});
    wr(5'h08, 8'h01);
    wr(5'h0c, 8'h40);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rdc(5'h08, 8'h00);
    // a write with lane 0 disabled must leave the bank pointer alone
    lane_en <= 4'h0;
    wr(5'h08, 8'h01);
    lane_en <= 4'h1;
    rdc(5'h08, 8'h00);
    wr(5'h0c, 8'h40);
    wr(5'h10, 8'h08);
    wr(5'h08, 8'h01);
    rdc(5'h10, 8'h00);
    wr(5'h10, 8'h04);
    rdc(5'h18, 8'h00);
  endtask
  task automatic t_write(input logic [5:0] a, input logic [7:0] d);
    open_ctl(a);
    wr(5'h04, d);
    wr(5'h14, 8'h06); // global enable off while launching
    wr(5'h10, 8'h08);
    wr(5'h10, 8'h0c);
    chk({7'h0, nvm_busy_o}, 8'h01);
    wr(5'h14, 8'h07);
    poll(2);
    wr(5'h10, 8'h00);
    wr(5'h08, 8'h00);
  endtask
  task automatic t_read(input logic [5:0] a, input logic [7:0] e);
    wr(5'h04, 8'h00);
    wr(5'h14, 8'h07);
    open_ctl(a);
    wr(5'h10, 8'h02);
    wr(5'h10, 8'h03);
    poll(0);
    rdc(5'h04, e);
    rdc(5'h14, 8'h07);
    wr(5'h10, 8'h00);
    wr(5'h08, 8'h00);
  endtask
  task automatic t_halt;
    open_ctl(6'h05);
    wr(5'h04, 8'h11);
    wr(5'h10, 8'h08);
    wr(5'h10, 8'h0c);
    power_down_i <= 1'b1;
    @(posedge ref_clk_i);
    power_down_i <= 1'b0;
    rdc(5'h18, 8'h02);
    rdc(5'h10, 8'h08);
    rdc(5'h14, 8'h07);
    wr(5'h10, 8'h00);
    wr(5'h08, 8'h00);
    t_read(6'h05, 8'ha5);
  endtask
  task automatic t_stack;
    stack_full_i <= 1'b1;
    t_write(6'h3f, 8'h3c);
    chk({7'h0, irq_vector_req_o}, 8'h00);
    rdc(5'h14, 8'h1f);
    stack_full_i <= 1'b0;
    @(posedge ref_clk_i);
    chk({7'h0, irq_vector_req_o}, 8'h01);
    repeat (3) @(posedge ref_clk_i);
    rdc(5'h14, 8'h17);
    t_read(6'h3f, 8'h3c);
  endtask
  // ****************************************
  // clock, watchdog and main sequence
  // ****************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    err_count++;
    tally_and_finish;
  end
  initial begin
    {reset_i, avs_read, avs_write, power_down_i, stack_full_i, take_en} = 6'b100001;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    lane_en = 4'h1;
    repeat (8) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    t_reset;
    t_write(6'h05, 8'ha5);
    rdc(5'h14, 8'h17);
    t_read(6'h05, 8'ha5);
    t_stack;
    t_halt;
    tally_and_finish;
  end
endmodule
`default_nettype wire
